// file: design/tcrc_top.sv
// block top: power down, pll enables, reference select, parallel clock divider, channels
// Notes on behaviour
// - each channel has separate transmit digital, receive analog, receive digital resets.
// - transmit digital reset clears tx buffer, encoder, xaui machine, test generators only.
// - receive digital reset clears aligner, rate matcher, decoder, rx buffer, verifiers.
// - receive analog reset clears deserializer, receive pll and recovery, analog only.
// - power down input or dropped enable shuts every stage of every channel.
// - one transmit pll for the block and one receive pll per channel.
// - transmit pll gives half rate serial clock; byte serializer adds divide by two.
// - clock divider makes parallel clock, forwarded per channel or as shared core clock.
// - with rate matcher, recovered clock to matcher, parallel clock afterwards.
// - without rate matcher, recovered clock drives all receive logic to the buffer.
// - reference from two pins, fabric or inter block; fabric only straight from pin.
// - recovered clock forwarded to fabric only when no rate matcher is used.
module tcrc_top
   import tcrc_pkg::*;
(
   // clock and reset
   input  wire logic                   sys_clk_i,
   input  wire logic                   rst_n_i,
   // configuration
   input  wire tcrc_pkg::tcrc_mode_t   mode_i,
   input  wire tcrc_pkg::tcrc_ref_t    ref_sel_i,
   input  wire logic                   fabric_ref_from_pin_i,
   // per channel resets
   input  wire logic [3:0]             tx_dig_rst_i,
   input  wire logic [3:0]             rx_ana_rst_i,
   input  wire logic [3:0]             rx_dig_rst_i,
   // block power
   input  wire logic                   blk_powerdown_i,
   input  wire logic                   blk_enable_i,
   input  wire logic                   cal_pd_i,
   input  wire logic                   link_busy_i,
   // channel stage control
   output logic [3:0][16:0]            stage_rst_o,
   output logic [3:0][4:0]             rx_clk_sel_o,
   output logic [3:0]                  rx_pll_en_o,
   output logic [3:0]                  rx_clkout_en_o,
   // block clocking
   output logic                        tx_pll_en_o,
   output logic                        par_clk_tick_o,
   output logic [3:0]                  tx_clkout_en_o,
   output logic                        coreclkout_en_o,
   output tcrc_pkg::tcrc_ref_t         ref_sel_o,
   output logic                        ref_sel_err_o,
   output logic                        fixedclk_req_o,
   // calibration
   output logic                        cal_pd_o,
   output logic                        cal_pd_hazard_o
);
   import tcrc_pkg::*;

   typedef struct packed {
      tcrc_stage_t [NUM_CHAN-1:0] stage_rst;
      tcrc_rxclk_t [NUM_CHAN-1:0] clk_sel;
      logic [NUM_RX_PLL-1:0]      rx_pll_en;
      logic [NUM_CHAN-1:0]        rx_clkout_en;
      logic                       tx_pll_en;
      logic [DIV_W-1:0]           div_cnt;
      logic [DIV_W-1:0]           div_per;
      logic                       tick;
      logic [NUM_CHAN-1:0]        tx_clkout_en;
      logic                       core_en;
      tcrc_ref_t                  ref_sel;
      logic                       ref_err;
      logic                       fixedclk_req;
      logic                       cal_pd;
      logic                       cal_hazard;
   } tcrc_top_st_t;

   localparam tcrc_top_st_t TOP_RST = '{
      stage_rst: '1, clk_sel: '0, rx_pll_en: '0, rx_clkout_en: '0, tx_pll_en: 1'b0,
      div_cnt: '0, div_per: DIV_PLAIN, tick: 1'b0, tx_clkout_en: '0, core_en: 1'b0,
      ref_sel: REF_RST, ref_err: 1'b0, fixedclk_req: 1'b0, cal_pd: 1'b0,
      cal_hazard: 1'b0};

   tcrc_top_st_t st_q;
   tcrc_top_st_t st_d;

   logic             pd_w;
   logic             rm_w;
   logic             bs_w;
   logic             bonded_w;
   logic [DIV_W-1:0] per_w;
   tcrc_stage_t      chan_rst_w [NUM_CHAN];
   tcrc_rxclk_t      chan_sel_w [NUM_CHAN];
   logic             chan_fwd_w [NUM_CHAN];
   logic             chan_pll_w [NUM_CHAN];

   // block shutdown from either power input
   assign pd_w     = blk_powerdown_i || !blk_enable_i;
   assign rm_w     = RM_MODE_MAP[mode_i];
   assign bs_w     = BS_MODE_MAP[mode_i];
   assign bonded_w = (mode_i == MODE_XAUI);
   assign per_w    = bs_w ? DIV_BYTE_SER : DIV_PLAIN;

   tcrc_chan_if cif [NUM_CHAN] ();

   // one receive pll and stage map per channel
   for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
      assign cif[g].tx_dig  = tx_dig_rst_i[g];
      assign cif[g].rx_ana  = rx_ana_rst_i[g];
      assign cif[g].rx_dig  = rx_dig_rst_i[g];
      assign cif[g].pd      = pd_w;
      assign cif[g].rm_used = rm_w;
      assign chan_rst_w[g]  = cif[g].stage_rst;
      assign chan_sel_w[g]  = cif[g].clk_sel;
      assign chan_fwd_w[g]  = cif[g].clkout_en;
      assign chan_pll_w[g]  = cif[g].rx_pll_en;
      tcrc_chan u_chan (
         .sys_clk_i (sys_clk_i),
         .rst_n_i   (rst_n_i),
         .bus       (cif[g])
      );
   end

   always_comb begin
      st_d = st_q;
      for (int c = 0; c < NUM_CHAN; c++) begin
         st_d.stage_rst[c]    = chan_rst_w[c];
         st_d.clk_sel[c]      = chan_sel_w[c];
         st_d.rx_clkout_en[c] = chan_fwd_w[c];
         st_d.rx_pll_en[c]    = chan_pll_w[c];
      end
      // the single transmit pll serves the whole block
      st_d.tx_pll_en = !pd_w;
      // parallel clock divider; restarts when the ratio changes
      st_d.div_per = per_w;
      st_d.tick    = 1'b0;
      if (pd_w || (per_w != st_q.div_per)) begin
         st_d.div_cnt = '0;
      end else if (st_q.div_cnt == (per_w - DIV_W'(1))) begin
         st_d.div_cnt = '0;
         st_d.tick    = 1'b1;
      end else begin
         st_d.div_cnt = st_q.div_cnt + DIV_W'(1);
      end
      // bonded mode shares one core clock, otherwise each channel forwards its own
      st_d.core_en      = !pd_w && bonded_w;
      st_d.tx_clkout_en = (pd_w || bonded_w) ? '0 : '1;
      // fabric source accepted only when it comes straight from an input pin
      if ((ref_sel_i == REF_FABRIC) && !fabric_ref_from_pin_i) begin
         st_d.ref_err = 1'b1;
      end else begin
         st_d.ref_sel = ref_sel_i;
         st_d.ref_err = 1'b0;
      end
      st_d.fixedclk_req = !pd_w && (mode_i == MODE_PIPE);
      st_d.cal_pd       = cal_pd_i;
      st_d.cal_hazard   = cal_pd_i && link_busy_i;
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= TOP_RST;
      end else begin
         st_q <= st_d;
      end
   end

   always_comb begin
      for (int c = 0; c < NUM_CHAN; c++) begin
         stage_rst_o[c]  = st_q.stage_rst[c];
         rx_clk_sel_o[c] = st_q.clk_sel[c];
      end
   end

   assign rx_pll_en_o     = st_q.rx_pll_en;
   assign rx_clkout_en_o  = st_q.rx_clkout_en;
   assign tx_pll_en_o     = st_q.tx_pll_en;
   assign par_clk_tick_o  = st_q.tick;
   assign tx_clkout_en_o  = st_q.tx_clkout_en;
   assign coreclkout_en_o = st_q.core_en;
   assign ref_sel_o       = st_q.ref_sel;
   assign ref_sel_err_o   = st_q.ref_err;
   assign fixedclk_req_o  = st_q.fixedclk_req;
   assign cal_pd_o        = st_q.cal_pd;
   assign cal_pd_hazard_o = st_q.cal_hazard;

   sequence s_fabric_bad;
      (ref_sel_i == REF_FABRIC) && !fabric_ref_from_pin_i;
   endsequence

   sequence s_fabric_ok;
      (ref_sel_i != REF_FABRIC) || fabric_ref_from_pin_i;
   endsequence

   sequence s_plain_run;
      (!pd_w && !bs_w && st_q.div_per == DIV_PLAIN)[*6];
   endsequence

   a_ref_fabric_guard: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      s_fabric_bad |=> ref_sel_err_o && (ref_sel_o == $past(ref_sel_o)))
      else $error("fabric reference taken without pin source");
   a_ref_take: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      s_fabric_ok |=> !ref_sel_err_o && (ref_sel_o == $past(ref_sel_i)))
      else $error("legal reference select not taken");
   a_par_tick_gap: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      par_clk_tick_o |=> !par_clk_tick_o [*4])
      else $error("parallel clock ticks closer than five cycles");
   a_par_tick_plain: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      s_plain_run ##0 par_clk_tick_o ##1 (!pd_w && !bs_w) [*4] |=> par_clk_tick_o)
      else $error("plain mode parallel clock period wrong");
   a_pd_tick_stop: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      pd_w |=> !par_clk_tick_o && !tx_pll_en_o && !coreclkout_en_o && (tx_clkout_en_o == '0))
      else $error("clocking alive during power down");
   a_core_fwd: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (!pd_w && bonded_w) |=> coreclkout_en_o && (tx_clkout_en_o == '0))
      else $error("bonded mode not forwarding core clock");
   a_rx_fwd_rm: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      rm_w [*2] |=> (rx_clkout_en_o == '0))
      else $error("recovered clock forwarded with rate matcher");
   a_fixedclk_pipe: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (mode_i != MODE_PIPE) |=> !fixedclk_req_o)
      else $error("fixed clock requested outside pipe mode");
   a_cal_hazard: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (cal_pd_i && link_busy_i) |=> cal_pd_hazard_o && cal_pd_o)
      else $error("calibration power down under traffic not flagged");
endmodule : tcrc_top

// file: design/tcrc_pkg.sv
// constants and types for the transceiver reset and clocking control
package tcrc_pkg;
   localparam int NUM_CHAN    = 4;
   localparam int NUM_RX_PLL  = NUM_CHAN;
   localparam int NUM_STAGE   = 17;
   localparam int NUM_RX_CLK  = 5;
   // stage bit positions in a channel reset vector
   localparam int ST_TX_PCOMP = 0;
   localparam int ST_TX_ENC   = 1;
   localparam int ST_TX_SER   = 2;
   localparam int ST_TX_ANA   = 3;
   localparam int ST_TX_PLL   = 4;
   localparam int ST_TX_XAUI  = 5;
   localparam int ST_BIST_GEN = 6;
   localparam int ST_RX_DESER = 7;
   localparam int ST_RX_ALIGN = 8;
   localparam int ST_RX_DESKW = 9;
   localparam int ST_RX_RMAT  = 10;
   localparam int ST_RX_DEC   = 11;
   localparam int ST_RX_PCOMP = 12;
   localparam int ST_RX_CRU   = 13;
   localparam int ST_RX_XAUI  = 14;
   localparam int ST_BIST_VER = 15;
   localparam int ST_RX_ANA   = 16;
   // receive stage clock select positions: 1 = parallel clock, 0 = recovered clock
   localparam int RC_ALIGN    = 0;
   localparam int RC_DESKW    = 1;
   localparam int RC_RMAT     = 2;
   localparam int RC_DEC      = 3;
   localparam int RC_PCOMP    = 4;
   typedef logic [NUM_STAGE-1:0]  tcrc_stage_t;
   typedef logic [NUM_RX_CLK-1:0] tcrc_rxclk_t;
   localparam tcrc_stage_t ST_ONE = tcrc_stage_t'(1);
   localparam tcrc_stage_t TX_DIG_MASK = (ST_ONE << ST_TX_PCOMP) | (ST_ONE << ST_TX_ENC)
                                       | (ST_ONE << ST_TX_XAUI) | (ST_ONE << ST_BIST_GEN);
   localparam tcrc_stage_t RX_DIG_MASK = (ST_ONE << ST_RX_ALIGN) | (ST_ONE << ST_RX_RMAT)
                                       | (ST_ONE << ST_RX_DEC) | (ST_ONE << ST_RX_PCOMP)
                                       | (ST_ONE << ST_RX_XAUI) | (ST_ONE << ST_BIST_VER);
   localparam tcrc_stage_t RX_ANA_MASK = (ST_ONE << ST_RX_DESER) | (ST_ONE << ST_RX_CRU)
                                       | (ST_ONE << ST_RX_ANA);
   localparam tcrc_stage_t TX_HOLD_MASK = (ST_ONE << ST_TX_SER) | (ST_ONE << ST_TX_ANA)
                                        | (ST_ONE << ST_TX_PLL);
   localparam tcrc_rxclk_t RXC_ONE = tcrc_rxclk_t'(1);
   localparam tcrc_rxclk_t RX_CLK_RM_SEL = (RXC_ONE << RC_RMAT) | (RXC_ONE << RC_DEC)
                                         | (RXC_ONE << RC_PCOMP);
   localparam tcrc_rxclk_t RX_CLK_NORM_SEL = '0;
   typedef enum logic [2:0] {
      MODE_BASIC, MODE_GIGE, MODE_XAUI, MODE_PIPE, MODE_SRIO, MODE_SDI
   } tcrc_mode_t;
   typedef enum logic [1:0] {
      REF_PIN_A, REF_PIN_B, REF_FABRIC, REF_INTER_BLK
   } tcrc_ref_t;
   localparam tcrc_ref_t REF_RST = REF_PIN_A;
   // per mode, indexed by the mode code
   localparam logic [7:0] RM_MODE_MAP = 8'h0e;
   localparam logic [7:0] BS_MODE_MAP = 8'h0d;
   // serial clock runs at half the data rate; parallel word is ten bits
   localparam int SER_CLK_DIV  = 2;
   localparam int PAR_WIDTH    = 10;
   localparam int PAR_DIV      = PAR_WIDTH / SER_CLK_DIV;
   localparam int BYTE_SER_DIV = 2;
   localparam int DIV_W        = 4;
   localparam logic [DIV_W-1:0] DIV_PLAIN    = DIV_W'(PAR_DIV);
   localparam logic [DIV_W-1:0] DIV_BYTE_SER = DIV_W'(PAR_DIV * BYTE_SER_DIV);
endpackage : tcrc_pkg

// file: design/tcrc_chan_if.sv
// per channel control and stage steering between the block and one channel unit
interface tcrc_chan_if;
   import tcrc_pkg::*;
   logic        tx_dig;
   logic        rx_ana;
   logic        rx_dig;
   logic        pd;
   logic        rm_used;
   tcrc_stage_t stage_rst;
   tcrc_rxclk_t clk_sel;
   logic        clkout_en;
   logic        rx_pll_en;
   modport ctl  (output tx_dig, rx_ana, rx_dig, pd, rm_used,
                 input  stage_rst, clk_sel, clkout_en, rx_pll_en);
   modport chan (input  tx_dig, rx_ana, rx_dig, pd, rm_used,
                 output stage_rst, clk_sel, clkout_en, rx_pll_en);
endinterface : tcrc_chan_if

// file: design/tcrc_chan.sv
// one channel: reset map to stages, receive clock steering, recovered clock forward
module tcrc_chan (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // block side
   tcrc_chan_if.chan bus
);
   import tcrc_pkg::*;

   typedef struct packed {
      tcrc_stage_t rst;
      tcrc_rxclk_t clk_sel;
      logic        clkout_en;
      logic        rx_pll_en;
   } tcrc_chan_st_t;

   localparam tcrc_chan_st_t CHAN_RST = '{rst: '1, clk_sel: '0, clkout_en: 1'b0,
                                          rx_pll_en: 1'b0};

   tcrc_chan_st_t st_q;
   tcrc_chan_st_t st_d;

   always_comb begin
      st_d = st_q;
      st_d.rst = '0;
      if (bus.tx_dig) begin
         st_d.rst = st_d.rst | TX_DIG_MASK;
      end
      if (bus.rx_dig) begin
         st_d.rst = st_d.rst | RX_DIG_MASK;
      end
      if (bus.rx_ana) begin
         st_d.rst = st_d.rst | RX_ANA_MASK;
      end
      if (bus.pd) begin
         st_d.rst = '1;
      end
      st_d.clk_sel   = bus.rm_used ? RX_CLK_RM_SEL : RX_CLK_NORM_SEL;
      st_d.clkout_en = !bus.rm_used && !bus.pd;
      st_d.rx_pll_en = !bus.rx_ana && !bus.pd;
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= CHAN_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign bus.stage_rst = st_q.rst;
   assign bus.clk_sel   = st_q.clk_sel;
   assign bus.clkout_en = st_q.clkout_en;
   assign bus.rx_pll_en = st_q.rx_pll_en;

   a_tx_rst_scope: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      bus.tx_dig |=> ((st_q.rst & TX_DIG_MASK) == TX_DIG_MASK))
      else $error("transmit digital reset missed a stage");
   a_tx_hold_path: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (rst_n_i && !bus.pd) |=> ((st_q.rst & TX_HOLD_MASK) == '0))
      else $error("serializer or transmit pll reset without power down");
   a_rx_dig_scope: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (bus.rx_dig && !bus.rx_ana && !bus.pd) |=>
         ((st_q.rst & RX_DIG_MASK) == RX_DIG_MASK) && ((st_q.rst & RX_ANA_MASK) == '0))
      else $error("receive digital reset scope wrong");
   a_rx_ana_scope: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (bus.rx_ana && !bus.rx_dig && !bus.tx_dig && !bus.pd) |=>
         (st_q.rst == RX_ANA_MASK) && !st_q.rx_pll_en)
      else $error("receive analog reset scope wrong");
   a_pd_all_stages: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      bus.pd |=> (&st_q.rst) && !st_q.clkout_en)
      else $error("power down left a stage running");
   a_rx_clk_steer: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      bus.rm_used |=> st_q.clk_sel[RC_RMAT] && !st_q.clk_sel[RC_ALIGN] && !st_q.clkout_en)
      else $error("rate matcher clock steering wrong");
endmodule : tcrc_chan

// file: tb/tcrc_fabric_model.sv
// fabric side model: drives resets, power, reference and calibration controls into the block
module tcrc_fabric_model
   import tcrc_pkg::*;
(
   // clock and reset
   input  wire logic                 sys_clk_i,
   input  wire logic                 rst_n_i,
   // commands from the bench
   input  wire tcrc_pkg::tcrc_mode_t cmd_mode_i,
   input  wire tcrc_pkg::tcrc_ref_t  cmd_ref_i,
   input  wire logic                 cmd_pin_i,
   input  wire logic [3:0]           cmd_tx_i,
   input  wire logic [3:0]           cmd_rxa_i,
   input  wire logic [3:0]           cmd_rxd_i,
   input  wire logic                 cmd_pdn_i,
   input  wire logic                 cmd_en_i,
   input  wire logic                 cmd_cal_i,
   input  wire logic                 cmd_busy_i,
   input  wire logic                 cmd_bad_i,
   // block status
   input  wire logic                 fixedclk_req_i,
   // controls to the block
   output tcrc_pkg::tcrc_mode_t      mode_o,
   output tcrc_pkg::tcrc_ref_t       ref_sel_o,
   output logic                      from_pin_o,
   output logic [3:0]                tx_o,
   output logic [3:0]                rxa_o,
   output logic [3:0]                rxd_o,
   output logic                      pdn_o,
   output logic                      en_o,
   output logic                      cal_o,
   output logic                      busy_o,
   output logic                      fixedclk_o
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_o     <= MODE_BASIC;
         ref_sel_o  <= REF_PIN_A;
         from_pin_o <= 1'b1;
         {tx_o, rxa_o, rxd_o} <= 12'h000;
         {pdn_o, en_o, cal_o, busy_o, fixedclk_o} <= 5'h08;
      end else begin
         mode_o     <= cmd_mode_i;
         ref_sel_o  <= cmd_ref_i;
         from_pin_o <= cmd_pin_i;
         tx_o       <= cmd_tx_i;
         rxa_o      <= cmd_rxa_i;
         rxd_o      <= cmd_rxd_i;
         pdn_o      <= cmd_pdn_i;
         en_o       <= cmd_en_i;
         busy_o     <= cmd_busy_i;
         // calibration stays up under traffic unless told to misbehave
         cal_o      <= cmd_cal_i & (!cmd_busy_i | cmd_bad_i);
         fixedclk_o <= fixedclk_req_i ? !fixedclk_o : 1'b0;
      end
   end
endmodule : tcrc_fabric_model

// file: tb/test_tcrc_top.sv
// self-checking bench for the transceiver reset and clocking block
module test_tcrc_top;
   timeunit 1ns;
   timeprecision 1ps;
   import tcrc_pkg::*;
   typedef struct {
      tcrc_mode_t mode; tcrc_ref_t rs; logic pin; logic [3:0] tx, rxa, rxd;
      logic pdn, en, cal, busy; tcrc_ref_t exp_ref;
   } tcrc_row_t;
   logic sys_clk_i = 1'b0, rst_n_i = 1'b0, fixedclk;
   tcrc_mode_t c_mode = MODE_BASIC, mode;
   tcrc_ref_t c_ref = REF_PIN_A, rsel, ref_sel_o;
   logic c_pin = 1'b1, c_pdn = 1'b0, c_en = 1'b1, c_cal = 1'b0, c_busy = 1'b0, c_bad = 1'b0;
   logic [3:0] c_tx = 4'h0, c_rxa = 4'h0, c_rxd = 4'h0, tx, rxa, rxd;
   logic pin, pdn, en, cal, busy;
   logic [3:0][16:0] stage_rst_o;
   logic [3:0][4:0]  rx_clk_sel_o;
   logic [3:0]       rx_pll_en_o, rx_clkout_en_o, tx_clkout_en_o;
   logic tx_pll_en_o, par_clk_tick_o, coreclkout_en_o, ref_sel_err_o, fixedclk_req_o;
   logic cal_pd_o, cal_pd_hazard_o;
   int mismatches = 0, total_checks = 0, per;
   tcrc_row_t rows[10] = '{
      '{MODE_BASIC, REF_PIN_A,     1, 4'h1, 4'h0, 4'h0, 0, 1, 0, 0, REF_PIN_A},
      '{MODE_GIGE,  REF_PIN_B,     1, 4'h0, 4'h0, 4'h2, 0, 1, 0, 0, REF_PIN_B},
      '{MODE_XAUI,  REF_FABRIC,    1, 4'h0, 4'h4, 4'h0, 0, 1, 0, 0, REF_FABRIC},
      '{MODE_PIPE,  REF_INTER_BLK, 1, 4'hf, 4'hf, 4'hf, 0, 1, 0, 0, REF_INTER_BLK},
      '{MODE_SRIO,  REF_FABRIC,    0, 4'h5, 4'ha, 4'h3, 0, 1, 0, 0, REF_INTER_BLK},
      '{MODE_SDI,   REF_PIN_A,     0, 4'h0, 4'h0, 4'h0, 0, 1, 0, 0, REF_PIN_A},
      '{MODE_BASIC, REF_PIN_B,     1, 4'h0, 4'h0, 4'h0, 1, 1, 0, 0, REF_PIN_B},
      '{MODE_GIGE,  REF_PIN_A,     1, 4'h3, 4'h0, 4'h0, 0, 0, 0, 0, REF_PIN_A},
      '{MODE_XAUI,  REF_PIN_A,     1, 4'h0, 4'h0, 4'h0, 0, 1, 1, 0, REF_PIN_A},
      '{MODE_PIPE,  REF_PIN_B,     1, 4'h8, 4'h0, 4'h8, 0, 1, 0, 1, REF_PIN_B}};
   always #2 sys_clk_i = ~sys_clk_i;
   tcrc_fabric_model fabric (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cmd_mode_i(c_mode),
      .cmd_ref_i(c_ref), .cmd_pin_i(c_pin), .cmd_tx_i(c_tx), .cmd_rxa_i(c_rxa),
      .cmd_rxd_i(c_rxd), .cmd_pdn_i(c_pdn), .cmd_en_i(c_en), .cmd_cal_i(c_cal),
      .cmd_busy_i(c_busy), .cmd_bad_i(c_bad), .fixedclk_req_i(fixedclk_req_o), .mode_o(mode),
      .ref_sel_o(rsel), .from_pin_o(pin), .tx_o(tx), .rxa_o(rxa), .rxd_o(rxd), .pdn_o(pdn),
      .en_o(en), .cal_o(cal), .busy_o(busy), .fixedclk_o(fixedclk));
   tcrc_top DUT (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .mode_i(mode), .ref_sel_i(rsel),
      .fabric_ref_from_pin_i(pin), .tx_dig_rst_i(tx), .rx_ana_rst_i(rxa), .rx_dig_rst_i(rxd),
      .blk_powerdown_i(pdn), .blk_enable_i(en), .cal_pd_i(cal), .link_busy_i(busy),
      .stage_rst_o(stage_rst_o), .rx_clk_sel_o(rx_clk_sel_o), .rx_pll_en_o(rx_pll_en_o),
      .rx_clkout_en_o(rx_clkout_en_o), .tx_pll_en_o(tx_pll_en_o),
      .par_clk_tick_o(par_clk_tick_o), .tx_clkout_en_o(tx_clkout_en_o),
      .coreclkout_en_o(coreclkout_en_o), .ref_sel_o(ref_sel_o), .ref_sel_err_o(ref_sel_err_o),
      .fixedclk_req_o(fixedclk_req_o), .cal_pd_o(cal_pd_o), .cal_pd_hazard_o(cal_pd_hazard_o));
   task automatic check(input string name, input logic [67:0] seen, input logic [67:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : finish_test
   function automatic logic [16:0] exp_stage(logic t, logic a, logic d, logic p);
      if (p) begin
         return 17'h1ffff;
      end
      return (t ? 17'h00063 : 17'h0) | (d ? 17'h0dd00 : 17'h0) | (a ? 17'h12080 : 17'h0);
   endfunction : exp_stage
   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask : settle
   task automatic period_of(output int p);
      int n;
      n = 0;
      while (par_clk_tick_o !== 1'b1 && n < 40) begin
         settle(1);
         n++;
      end
      p = 0;
      do begin
         settle(1);
         p++;
      end while (par_clk_tick_o !== 1'b1 && p < 40);
   endtask : period_of
   initial begin
      repeat (5000) @(posedge sys_clk_i);
      mismatches++;
      finish_test();
   end
   initial begin
      logic pd, rm;
      settle(4);
      check("stage_rst reset", stage_rst_o, {4{17'h1ffff}});
      check("tx_pll_en reset", tx_pll_en_o, 0);
      @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      foreach (rows[i]) begin
         @(posedge sys_clk_i);
         c_mode <= rows[i].mode;
         c_ref  <= rows[i].rs;
         {c_pin, c_tx, c_rxa, c_rxd} <= {rows[i].pin, rows[i].tx, rows[i].rxa, rows[i].rxd};
         {c_pdn, c_en, c_cal, c_busy} <= {rows[i].pdn, rows[i].en, rows[i].cal, rows[i].busy};
         settle(6);
         pd = rows[i].pdn | !rows[i].en;
         rm = rows[i].mode inside {MODE_GIGE, MODE_XAUI, MODE_PIPE};
         for (int c = 0; c < 4; c++) begin
            check("stage_rst", stage_rst_o[c],
                  exp_stage(rows[i].tx[c], rows[i].rxa[c], rows[i].rxd[c], pd));
            check("rx_pll_en", rx_pll_en_o[c], !rows[i].rxa[c] && !pd);
            check("rx_clkout_en", rx_clkout_en_o[c], !rm && !pd);
            if (!pd) check("rx_clk_sel", rx_clk_sel_o[c], rm ? 5'h1c : 5'h00);
         end
         check("tx_pll_en", tx_pll_en_o, !pd);
         check("coreclkout_en", coreclkout_en_o, rows[i].mode == MODE_XAUI && !pd);
         check("tx_clkout_en", tx_clkout_en_o,
               (rows[i].mode != MODE_XAUI && !pd) ? 4'hf : 4'h0);
         check("fixedclk_req", fixedclk_req_o, rows[i].mode == MODE_PIPE && !pd);
         check("ref_sel", ref_sel_o, rows[i].exp_ref);
         check("ref_sel_err", ref_sel_err_o, rows[i].rs == REF_FABRIC && !rows[i].pin);
         check("cal_pd", cal_pd_o, rows[i].cal);
      end
      @(posedge sys_clk_i);
      {c_tx, c_rxa, c_rxd, c_pdn, c_en, c_cal, c_busy} <= {12'h000, 4'h4};
      c_mode <= MODE_BASIC;
      settle(30);
      period_of(per);
      check("period byte ser", per, 10);
      @(posedge sys_clk_i);
      c_mode <= MODE_GIGE;
      settle(30);
      period_of(per);
      check("period plain", per, 5);
      @(posedge sys_clk_i);
      c_cal <= 1'b1;
      c_busy <= 1'b1;
      settle(6);
      check("cal_pd held", cal_pd_o, 0);
      check("cal_pd_hazard clear", cal_pd_hazard_o, 0);
      @(posedge sys_clk_i);
      c_bad <= 1'b1;
      settle(6);
      check("cal_pd forced", cal_pd_o, 1);
      check("cal_pd_hazard", cal_pd_hazard_o, 1);
      @(posedge sys_clk_i);
      c_pdn <= 1'b1;
      settle(8);
      per = 0;
      repeat (20) begin
         settle(1);
         if (par_clk_tick_o !== 1'b0) per++;
      end
      check("ticks in power down", per, 0);
      @(posedge sys_clk_i);
      rst_n_i <= 1'b0;
      settle(1);
      check("stage_rst mid reset", stage_rst_o, {4{17'h1ffff}});
      check("ref_sel mid reset", ref_sel_o, REF_PIN_A);
      finish_test();
   end
endmodule : test_tcrc_top
